//--- design/drive_admin_pkg.sv
// Constants and types shared by the administrative command decoder
package drive_admin_pkg;

    // Task file register selects
    localparam logic [2:0] SEL_DATA = 3'h0;
    localparam logic [2:0] SEL_FEATURE = 3'h1;
    localparam logic [2:0] SEL_COUNT = 3'h2;
    localparam logic [2:0] SEL_ADDR_LOW = 3'h3;
    localparam logic [2:0] SEL_ADDR_MID = 3'h4;
    localparam logic [2:0] SEL_ADDR_HIGH = 3'h5;
    localparam logic [2:0] SEL_DEV_HEAD = 3'h6;
    localparam logic [2:0] SEL_COMMAND = 3'h7;

    // Command codes
    localparam logic [7:0] CMD_ERASE = 8'hC0;
    localparam logic [7:0] CMD_DIAG = 8'h90;
    localparam logic [7:0] CMD_FLUSH = 8'hE7;
    localparam logic [7:0] CMD_IDENTIFY = 8'hEC;

    // Field positions
    localparam int ST_BUSY = 7;
    localparam int ST_READY = 6;
    localparam int ST_FAULT = 5;
    localparam int ST_SEEK = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ERR_ABORT = 2;
    localparam int DH_LBA = 6;

    // Reset values
    localparam logic [7:0] STATUS_RST = 8'h50;
    localparam logic [7:0] ERROR_RST = 8'h01;
    localparam logic [7:0] COUNT_RST = 8'h01;

    // Diagnostic result codes
    localparam logic [7:0] DIAG_PASS = 8'h01;
    localparam logic [7:0] DIAG_FORMATTER = 8'h02;
    localparam logic [7:0] DIAG_BUFFER = 8'h03;
    localparam logic [7:0] DIAG_ECC = 8'h04;
    localparam logic [7:0] DIAG_CPU = 8'h05;

    // Identification block
    localparam logic [8:0] ID_WORDS = 9'h100;
    localparam logic [8:0] W_CONFIG = 9'h000;
    localparam logic [8:0] W_CYL = 9'h001;
    localparam logic [8:0] W_HEADS = 9'h003;
    localparam logic [8:0] W_SPT = 9'h006;
    localparam logic [8:0] W_SECT_HI = 9'h007;
    localparam logic [8:0] W_SECT_LO = 9'h008;
    localparam logic [8:0] W_SER_FIRST = 9'h00A;
    localparam logic [8:0] W_SER_LAST = 9'h013;
    localparam logic [8:0] W_BUF_TYPE = 9'h014;
    localparam logic [8:0] W_BUF_SIZE = 9'h015;
    localparam logic [8:0] W_FW_FIRST = 9'h017;
    localparam logic [8:0] W_FW_LAST = 9'h01A;
    localparam logic [8:0] W_MULTI = 9'h02F;
    localparam logic [8:0] W_DWORD = 9'h030;
    localparam logic [8:0] W_CAPS = 9'h031;
    localparam logic [8:0] W_CAPS2 = 9'h032;
    localparam logic [8:0] W_PIO = 9'h033;
    localparam logic [8:0] W_VALID = 9'h035;
    localparam logic [15:0] V_FIXED = 16'h044A;
    localparam logic [15:0] V_REMOVABLE = 16'h848A;
    localparam logic [15:0] V_BUF_TYPE = 16'h0002;
    localparam logic [15:0] V_BUF_SIZE = 16'h0002;
    localparam logic [15:0] V_MULTI = 16'h8001;
    localparam logic [15:0] V_DWORD = 16'h0000;
    localparam logic [15:0] V_CAPS_DMA = 16'h0F00;
    localparam logic [15:0] V_CAPS_NODMA = 16'h0E00;
    localparam logic [15:0] V_CAPS2 = 16'h4000;
    localparam logic [15:0] V_PIO = 16'h0200;
    localparam logic [15:0] V_VALID = 16'h0007;

    // Data buffer shape
    localparam int FIFO_WIDTH = 16;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_ERASE = 6'h02,
        S_FLUSH = 6'h04,
        S_DIAG = 6'h08,
        S_IDENT = 6'h10,
        S_DRAIN = 6'h20
    } cmd_state_t;

endpackage

//--- design/drive_admin_command_decoder.sv
// Administrative command decoder with its identification data buffer
//
// Summary of operation
// R1: Erase command conditions addressed sectors
// R2: Erase moves no data; fault shown
// R3: Start address from task file, lba-select
// R4: Erase count consecutive blocks from start
// R5: Diagnostic command runs internal tests
// R6: Diagnostic ignores drive select bit
// R7: Diagnostic result code in error register
// R8: Flush writes cache, then ready+seek status
// R9: Flush unsupported ends with command aborted
// R10: Identify returns block like sector read
// R11: Reserved identify bits and words zero
// R12: Word 0 fixed or removable value
// R13: Words 7-8 hold sector total
// R14: Words 10-19 hold serial number
// R15: Words 20-21 buffer type and size
// R16: Words 23-26 firmware, first char high
// R17: Word 47 multiple sector limit
// R18: Word 48 reads zero
// R19: Word 49 capabilities with/without DMA
// R20: Word 51 PIO mode 2, 52 zero
// R21: Word 53 field validity value
// R22: Host loads parameters before command code
// R23: Busy held until results are final
// R24: Unknown command aborted, state unchanged
`timescale 1ns/1ps
`default_nettype none

module id_data_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    // Nothing held anywhere
    output logic empty
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
        logic [WIDTH-1:0] out_data;
        logic out_valid;
        logic in_ready;
        logic empty;
    } fifo_state_t;

    localparam fifo_state_t FIFO_RST = '{in_ready: 1'b1, empty: 1'b1, default: '0};

    fifo_state_t q;
    fifo_state_t d;
    logic push;
    logic pop;

    always_comb begin
        d = q;
        push = in_valid && q.in_ready;
        pop = (q.count != '0) && (!q.out_valid || out_ready);
        if (q.out_valid && out_ready) begin
            d.out_valid = 1'b0;
        end
        // Output stage is a register so the top's outputs stay flop-driven
        if (pop) begin
            d.out_data = q.mem[q.rd];
            d.out_valid = 1'b1;
            d.rd = q.rd + AW'(1);
        end
        if (push) begin
            d.mem[q.wr] = in_data;
            d.wr = q.wr + AW'(1);
        end
        d.count = q.count + (AW+1)'(push) - (AW+1)'(pop);
        d.in_ready = d.count < (AW+1)'(DEPTH);
        d.empty = (d.count == '0) && !d.out_valid;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= FIFO_RST;
        end else begin
            q <= d;
        end
    end

    assign in_ready = q.in_ready;
    assign out_valid = q.out_valid;
    assign out_data = q.out_data;
    assign empty = q.empty;
endmodule

module drive_admin_command_decoder (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Task file access
    input wire logic tf_wr,
    input wire logic [2:0] tf_addr,
    input wire logic [7:0] tf_wdata,
    output logic [7:0] tf_rdata,
    // Command progress
    output logic busy,
    output logic cmd_done,
    // Identification data stream
    output logic [15:0] id_data,
    output logic id_valid,
    input wire logic id_ready,
    // Media erase engine
    output logic erase_req,
    output logic [27:0] erase_start,
    output logic erase_lba,
    output logic [8:0] erase_count,
    input wire logic erase_done,
    input wire logic erase_fault,
    // Write cache engine
    output logic flush_req,
    input wire logic flush_done,
    // Self test engine
    output logic diag_req,
    input wire logic diag_done,
    input wire logic [7:0] diag_code,
    // Drive configuration
    input wire logic cfg_removable,
    input wire logic cfg_no_dma,
    input wire logic cfg_flush_ok,
    input wire logic [31:0] total_sectors,
    input wire logic [15:0] def_cylinders,
    input wire logic [7:0] def_heads,
    input wire logic [15:0] def_sectors,
    input wire logic [159:0] serial_text,
    input wire logic [63:0] fw_text
);
    typedef struct packed {
        drive_admin_pkg::cmd_state_t st;
        logic [7:0] feature;
        logic [7:0] count;
        logic [7:0] addr_low;
        logic [7:0] addr_mid;
        logic [7:0] addr_high;
        logic [7:0] dev_head;
        logic [7:0] status;
        logic [7:0] error;
        logic [7:0] rdata;
        logic done;
        logic erase_req;
        logic [27:0] erase_start;
        logic erase_lba;
        logic [8:0] erase_count;
        logic flush_req;
        logic diag_req;
        logic [8:0] widx;
        logic [15:0] push_data;
        logic push_valid;
    } state_t;

    localparam state_t RST = '{
        st: drive_admin_pkg::S_IDLE,
        status: drive_admin_pkg::STATUS_RST,
        error: drive_admin_pkg::ERROR_RST,
        count: drive_admin_pkg::COUNT_RST,
        addr_low: drive_admin_pkg::COUNT_RST,
        default: '0
    };

    state_t q;
    state_t d;
    logic fifo_ready;
    logic fifo_empty;
    logic cmd_write;

    // Parameter block; anything not listed is reserved and reads zero
    function automatic logic [15:0] id_word(input logic [8:0] i);
        logic [15:0] w;
        w = 16'h0000; // R11
        case (i)
            drive_admin_pkg::W_CONFIG:
                w = cfg_removable ? drive_admin_pkg::V_REMOVABLE
                                  : drive_admin_pkg::V_FIXED; // R12
            drive_admin_pkg::W_CYL: w = def_cylinders;
            drive_admin_pkg::W_HEADS: w = {8'h00, def_heads};
            drive_admin_pkg::W_SPT: w = def_sectors;
            drive_admin_pkg::W_SECT_HI: w = total_sectors[31:16]; // R13
            drive_admin_pkg::W_SECT_LO: w = total_sectors[15:0]; // R13
            drive_admin_pkg::W_BUF_TYPE: w = drive_admin_pkg::V_BUF_TYPE; // R15
            drive_admin_pkg::W_BUF_SIZE: w = drive_admin_pkg::V_BUF_SIZE; // R15
            drive_admin_pkg::W_MULTI: w = drive_admin_pkg::V_MULTI; // R17
            drive_admin_pkg::W_DWORD: w = drive_admin_pkg::V_DWORD; // R18
            drive_admin_pkg::W_CAPS:
                w = cfg_no_dma ? drive_admin_pkg::V_CAPS_NODMA
                               : drive_admin_pkg::V_CAPS_DMA; // R19
            drive_admin_pkg::W_CAPS2: w = drive_admin_pkg::V_CAPS2;
            drive_admin_pkg::W_PIO: w = drive_admin_pkg::V_PIO; // R20
            drive_admin_pkg::W_VALID: w = drive_admin_pkg::V_VALID; // R21
            default: begin
                // Caller supplies the serial already right justified
                if (i >= drive_admin_pkg::W_SER_FIRST &&
                    i <= drive_admin_pkg::W_SER_LAST) begin
                    w = serial_text[16*(drive_admin_pkg::W_SER_LAST-i) +: 16]; // R14
                end
                if (i >= drive_admin_pkg::W_FW_FIRST &&
                    i <= drive_admin_pkg::W_FW_LAST) begin
                    w = fw_text[16*(drive_admin_pkg::W_FW_LAST-i) +: 16]; // R16
                end
            end
        endcase
        return w;
    endfunction

    // Ends a command with final status and error, raising completion in the same cycle
    function automatic state_t finish(input state_t s, input logic [7:0] stat,
                                      input logic [7:0] err);
        state_t r;
        r = s;
        r.st = drive_admin_pkg::S_IDLE;
        r.status = stat;
        r.error = err;
        r.done = 1'b1; // R23
        return r;
    endfunction

    localparam logic [7:0] ST_OK = 8'h50;
    localparam logic [7:0] ST_ABORT = 8'h51;

    assign cmd_write = tf_wr && (tf_addr == drive_admin_pkg::SEL_COMMAND);

    always_comb begin
        d = q;
        d.done = 1'b0;

        // Parameters are frozen while busy; they must be loaded first
        if (tf_wr && !q.status[drive_admin_pkg::ST_BUSY]) begin // R22
            case (tf_addr)
                drive_admin_pkg::SEL_FEATURE: d.feature = tf_wdata;
                drive_admin_pkg::SEL_COUNT: d.count = tf_wdata;
                drive_admin_pkg::SEL_ADDR_LOW: d.addr_low = tf_wdata;
                drive_admin_pkg::SEL_ADDR_MID: d.addr_mid = tf_wdata;
                drive_admin_pkg::SEL_ADDR_HIGH: d.addr_high = tf_wdata;
                drive_admin_pkg::SEL_DEV_HEAD: d.dev_head = tf_wdata;
                default: d.feature = q.feature;
            endcase
        end

        case (q.st)
            drive_admin_pkg::S_IDLE: begin
                if (cmd_write) begin
                    d.status = 8'h80; // R23
                    case (tf_wdata)
                        drive_admin_pkg::CMD_ERASE: begin
                            d.st = drive_admin_pkg::S_ERASE; // R1
                            d.erase_req = 1'b1;
                            d.erase_start = {q.dev_head[3:0], q.addr_high,
                                             q.addr_mid, q.addr_low}; // R3
                            d.erase_lba = q.dev_head[drive_admin_pkg::DH_LBA]; // R3
                            // A count of zero stands for 256 blocks
                            d.erase_count = (q.count == 8'h00) ? 9'h100
                                                               : {1'b0, q.count}; // R4
                        end
                        drive_admin_pkg::CMD_DIAG: begin
                            // Drive select is not looked at here
                            d.st = drive_admin_pkg::S_DIAG; // R5 R6
                            d.diag_req = 1'b1;
                        end
                        drive_admin_pkg::CMD_FLUSH: begin
                            if (cfg_flush_ok) begin
                                d.st = drive_admin_pkg::S_FLUSH; // R8
                                d.flush_req = 1'b1;
                            end else begin
                                d = finish(d, ST_ABORT, 8'h04); // R9
                            end
                        end
                        drive_admin_pkg::CMD_IDENTIFY: begin
                            d.st = drive_admin_pkg::S_IDENT; // R10
                            d.status = 8'h88;
                            d.widx = 9'h000;
                        end
                        default: begin
                            d = finish(d, ST_ABORT, 8'h04); // R24
                        end
                    endcase
                end
            end
            drive_admin_pkg::S_ERASE: begin
                // No data phase; a media fault ends with write fault
                if (erase_done) begin // R2
                    d.erase_req = 1'b0;
                    d = finish(d, erase_fault ? 8'h71 : ST_OK, 8'h00); // R2
                end
            end
            drive_admin_pkg::S_FLUSH: begin
                // Ready and seek complete only once the cache is on media
                if (flush_done) begin
                    d.flush_req = 1'b0;
                    d = finish(d, ST_OK, 8'h00); // R8
                end
            end
            drive_admin_pkg::S_DIAG: begin
                if (diag_done) begin
                    d.diag_req = 1'b0;
                    d = finish(d, ST_OK, diag_code); // R7
                end
            end
            drive_admin_pkg::S_IDENT: begin
                // Stalls whenever the buffer is full
                if (!q.push_valid || fifo_ready) begin
                    if (q.widx < drive_admin_pkg::ID_WORDS) begin
                        d.push_data = id_word(q.widx); // R10
                        d.push_valid = 1'b1;
                        d.widx = q.widx + 9'h001;
                    end else begin
                        d.push_valid = 1'b0;
                        d.st = drive_admin_pkg::S_DRAIN;
                    end
                end
            end
            drive_admin_pkg::S_DRAIN: begin
                if (fifo_empty) begin
                    d = finish(d, ST_OK, 8'h00); // R10 R23
                end
            end
            default: begin
                d = RST;
            end
        endcase

        // Registered read-back; status and error share selects with writes
        case (tf_addr)
            drive_admin_pkg::SEL_FEATURE: d.rdata = q.error;
            drive_admin_pkg::SEL_COUNT: d.rdata = q.count;
            drive_admin_pkg::SEL_ADDR_LOW: d.rdata = q.addr_low;
            drive_admin_pkg::SEL_ADDR_MID: d.rdata = q.addr_mid;
            drive_admin_pkg::SEL_ADDR_HIGH: d.rdata = q.addr_high;
            drive_admin_pkg::SEL_DEV_HEAD: d.rdata = q.dev_head;
            drive_admin_pkg::SEL_COMMAND: d.rdata = q.status;
            default: d.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    id_data_fifo #(
        .WIDTH(drive_admin_pkg::FIFO_WIDTH),
        .DEPTH(drive_admin_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(q.push_valid),
        .in_data(q.push_data),
        .in_ready(fifo_ready),
        .out_valid(id_valid),
        .out_data(id_data),
        .out_ready(id_ready),
        .empty(fifo_empty)
    );

    assign tf_rdata = q.rdata;
    assign busy = q.status[drive_admin_pkg::ST_BUSY];
    assign cmd_done = q.done;
    assign erase_req = q.erase_req;
    assign erase_start = q.erase_start;
    assign erase_lba = q.erase_lba;
    assign erase_count = q.erase_count;
    assign flush_req = q.flush_req;
    assign diag_req = q.diag_req;
endmodule

`default_nettype wire

//--- dv/drive_admin_chk.sv
// Concurrent checks on the administrative command decoder ports
`timescale 1ns/1ps
`default_nettype none
module drive_admin_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Task file and progress
    input wire logic tf_wr,
    input wire logic [2:0] tf_addr,
    input wire logic [7:0] tf_wdata,
    input wire logic busy,
    input wire logic cmd_done,
    // Identification stream
    input wire logic [15:0] id_data,
    input wire logic id_valid,
    input wire logic id_ready,
    // Engines
    input wire logic erase_req,
    input wire logic erase_done,
    input wire logic flush_req,
    input wire logic flush_done,
    input wire logic diag_req,
    input wire logic diag_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic cmd_go;
    assign cmd_go = tf_wr && tf_addr == 3'h7 && !busy;
    property p_erase_go; cmd_go && tf_wdata == 8'hC0 |=> busy && erase_req; endproperty
    a_erase_go: assert property (p_erase_go) else $error("erase not started");
    property p_diag_go; cmd_go && tf_wdata == 8'h90 |=> busy && diag_req; endproperty
    a_diag_go: assert property (p_diag_go) else $error("diagnostic not started");
    property p_ident_go; cmd_go && tf_wdata == 8'hEC |=> busy ##3 id_valid; endproperty
    a_ident_go: assert property (p_ident_go) else $error("identify data late");
    property p_unknown;
        cmd_go && !(tf_wdata inside {8'hC0, 8'h90, 8'hE7, 8'hEC}) |=> !busy && cmd_done;
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown code not aborted");
    property p_no_data; erase_req |-> !id_valid; endproperty
    a_no_data: assert property (p_no_data) else $error("data during erase");
    property p_erase_end; erase_req && erase_done |=> !erase_req && !busy && cmd_done; endproperty
    a_erase_end: assert property (p_erase_end) else $error("erase end wrong");
    property p_flush_end; flush_req && flush_done |=> !flush_req && !busy && cmd_done; endproperty
    a_flush_end: assert property (p_flush_end) else $error("flush end wrong");
    property p_diag_end; diag_req && diag_done |=> !diag_req && !busy && cmd_done; endproperty
    a_diag_end: assert property (p_diag_end) else $error("diagnostic end wrong");
    property p_done_once; cmd_done |=> !cmd_done; endproperty
    a_done_once: assert property (p_done_once) else $error("completion too long");
    property p_busy_run; erase_req || flush_req || diag_req |-> busy; endproperty
    a_busy_run: assert property (p_busy_run) else $error("idle while running");
    property p_id_hold; id_valid && !id_ready |=> id_valid && $stable(id_data); endproperty
    a_id_hold: assert property (p_id_hold) else $error("word dropped in stall");
    c_erase: cover property (erase_req && erase_done);
    c_stall: cover property (id_valid && !id_ready);
    c_abort: cover property (cmd_go ##1 cmd_done);
endmodule
`default_nettype wire

//--- dv/engine_model.sv
// Behavioural erase, cache or self-test engine answering one request line
`timescale 1ns/1ps
`default_nettype none
module engine_model #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Request and answer
    input wire logic req,
    input wire logic [3:0] lat,
    input wire logic [W-1:0] val,
    output logic done,
    output logic [W-1:0] val_out
);
    logic [3:0] cnt;
    logic fired;
    // Result lines carry garbage outside the done cycle
    assign val_out = done ? val : ~val;
    always @(posedge clk) begin
        if (reset || !req) begin
            cnt <= 4'h0;
            fired <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!fired && cnt == lat) begin
                done <= 1'b1;
                fired <= 1'b1;
            end else if (!fired) begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the administrative command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, reset = 1'b1, tf_wr = 1'b0, id_ready = 1'b0, hold = 1'b1;
    logic [2:0] tf_addr = 3'h0;
    logic [7:0] tf_wdata = 8'h00, tf_rdata, diag_code, code_val = 8'h01;
    logic busy, cmd_done, id_valid, erase_req, erase_lba, flush_req, diag_req;
    logic erase_done, erase_fault, flush_done, diag_done, fault_val = 1'b0;
    logic [15:0] id_data;
    logic [27:0] erase_start;
    logic [8:0] erase_count;
    logic [3:0] lat = 4'h0;
    logic cfg_removable = 1'b0, cfg_no_dma = 1'b0, cfg_flush_ok = 1'b1;
    logic [31:0] total_sectors = 32'h0;
    logic [15:0] def_cylinders = 16'h0, def_sectors = 16'h0;
    logic [7:0] def_heads = 8'h0;
    logic [159:0] serial_text = 160'h0;
    logic [63:0] fw_text = 64'h0;
    logic rd_en = 1'b0, rd_pipe = 1'b0, er_q = 1'b0;
    logic [7:0] q_reg[$];
    logic [15:0] q_id[$];
    logic [37:0] q_er[$];
    int n_errors = 0;
    int checks = 0;

    drive_admin_command_decoder drive_admin_command_decoder_i (.clk, .reset, .tf_wr, .tf_addr,
        .tf_wdata, .tf_rdata, .busy, .cmd_done, .id_data, .id_valid, .id_ready, .erase_req,
        .erase_start, .erase_lba, .erase_count, .erase_done, .erase_fault, .flush_req,
        .flush_done, .diag_req, .diag_done, .diag_code, .cfg_removable, .cfg_no_dma,
        .cfg_flush_ok, .total_sectors, .def_cylinders, .def_heads, .def_sectors,
        .serial_text, .fw_text);
    engine_model #(.W(1)) erase_engine_model_i (.clk, .reset, .req(erase_req), .lat,
        .val(fault_val), .done(erase_done), .val_out(erase_fault));
    engine_model #(.W(1)) flush_engine_model_i (.clk, .reset, .req(flush_req), .lat,
        .val(1'b0), .done(flush_done), .val_out());
    engine_model #(.W(8)) diag_engine_model_i (.clk, .reset, .req(diag_req), .lat,
        .val(code_val), .done(diag_done), .val_out(diag_code));

    always #4 clk = ~clk;
    always @(negedge clk) id_ready = hold ? 1'b0 : 1'(($urandom % 3) != 0);

    task automatic report(input logic [37:0] got, input logic [37:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e); report(38'(g), 38'(e)); endtask
    task automatic cmp_word(input logic [15:0] g, input logic [15:0] e); report(38'(g), 38'(e)); endtask
    task automatic cmp_erase(input logic [37:0] g, input logic [37:0] e); report(g, e); endtask

    // Results are judged here, apart from the driver
    always @(posedge clk) begin
        if (rd_pipe) cmp_reg(tf_rdata, q_reg.pop_front());
        rd_pipe <= rd_en;
        if (id_valid && id_ready) cmp_word(id_data, q_id.pop_front());
        if (erase_req && !er_q) cmp_erase({erase_lba, erase_count, erase_start}, q_er.pop_front());
        er_q <= erase_req;
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        tf_wr = 1'b1;
        tf_addr = a;
        tf_wdata = d;
        @(negedge clk);
        tf_wr = 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(negedge clk);
        tf_addr = a;
        rd_en = 1'b1;
        q_reg.push_back(e);
        @(negedge clk);
        rd_en = 1'b0;
    endtask
    task automatic wait_done();
        int i = 0;
        while (cmd_done !== 1'b1 && i < 4000) begin
            @(negedge clk);
            i++;
        end
        report({37'h0, cmd_done}, 38'h1);
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] st, input logic [7:0] er);
        wr(3'h7, c);
        wait_done();
        rd(3'h7, st);
        rd(3'h1, er);
    endtask
    function automatic logic [15:0] idw(input int i);
        case (i)
            0: return cfg_removable ? 16'h848A : 16'h044A;
            1: return def_cylinders;
            3: return {8'h00, def_heads};
            6: return def_sectors;
            7: return total_sectors[31:16];
            8: return total_sectors[15:0];
            20, 21: return 16'h0002;
            47: return 16'h8001;
            49: return cfg_no_dma ? 16'h0E00 : 16'h0F00;
            50: return 16'h4000;
            51: return 16'h0200;
            53: return 16'h0007;
            default: ;
        endcase
        if (i >= 10 && i <= 19) return serial_text[159-16*(i-10) -: 16];
        if (i >= 23 && i <= 26) return fw_text[63-16*(i-23) -: 16];
        return 16'h0000;
    endfunction
    task automatic summarize();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        #(40000 * 8);
        n_errors++;
        summarize();
    end

    initial begin
        int i, e;
        logic [63:0] p;
        logic [7:0] rst_v[8] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h50};
        i = $urandom(83);
        total_sectors = $urandom;
        {def_cylinders, def_sectors} = $urandom;
        def_heads = 8'($urandom);
        serial_text = {$urandom, $urandom, $urandom, $urandom, $urandom};
        fw_text = {$urandom, $urandom};
        repeat (12) @(negedge clk);
        reset = 1'b0;
        for (i = 1; i < 8; i++) rd(3'(i), rst_v[i]);
        for (i = 2; i < 7; i++) begin
            p[7:0] = 8'($urandom);
            wr(3'(i), p[7:0]);
            rd(3'(i), p[7:0]);
        end
        // Count zero first, then a write fault, then writes while busy
        for (e = 0; e < 3; e++) begin
            p = {$urandom, $urandom};
            if (e == 0) p[7:0] = 8'h00;
            for (i = 0; i < 5; i++) wr(3'(i + 2), p[8*i +: 8]);
            q_er.push_back({p[38], p[7:0] == 8'h00 ? 9'h100 : {1'b0, p[7:0]},
                p[35:32], p[31:24], p[23:16], p[15:8]});
            lat = (e == 2) ? 4'hF : 4'($urandom);
            fault_val = (e == 1);
            wr(3'h7, 8'hC0);
            if (e == 2) begin
                wr(3'h2, ~p[7:0]);
                wr(3'h7, 8'h90);
            end
            wait_done();
            rd(3'h7, e == 1 ? 8'h71 : 8'h50);
            rd(3'h1, 8'h00);
            rd(3'h2, p[7:0]);
        end
        wr(3'h6, 8'h10);
        for (i = 1; i < 6; i++) begin
            code_val = 8'(i);
            lat = 4'($urandom);
            cmd(8'h90, 8'h50, 8'(i));
        end
        cmd(8'hE7, 8'h50, 8'h00);
        cfg_flush_ok = 1'b0;
        cmd(8'hE7, 8'h51, 8'h04);
        wr(3'h2, 8'h3C);
        cmd(8'h20, 8'h51, 8'h04);
        rd(3'h2, 8'h3C);
        for (e = 0; e < 2; e++) begin
            cfg_removable = e[0];
            cfg_no_dma = e[0];
            for (i = 0; i < 256; i++) q_id.push_back(idw(i));
            hold = 1'b1;
            wr(3'h7, 8'hEC);
            repeat (20) @(negedge clk);
            hold = 1'b0;
            wait_done();
            rd(3'h7, 8'h50);
            rd(3'h1, 8'h00);
            report(38'(q_id.size()), 38'h0);
        end
        repeat (4) @(negedge clk);
        summarize();
    end
endmodule

bind drive_admin_command_decoder drive_admin_chk drive_admin_chk_i (.clk, .reset, .tf_wr,
    .tf_addr, .tf_wdata, .busy, .cmd_done, .id_data, .id_valid, .id_ready, .erase_req,
    .erase_done, .flush_req, .flush_done, .diag_req, .diag_done);
`default_nettype wire
